// file: core/mcp_dev.sv
// Function
// - Latch port address straps at reset release
// - Act only when frame port address matches
// - Controller clocks management link up to 25MHz
// - Sample data line on rising clock edge
// - Need thirty-two ones preamble, else ignore
// - Start pattern 00 follows the preamble
// - Decode opcode: address, write, read, read-increment
// - Read-increment returns data then bumps address
// - Port then device address, MSB first
// - Controller drives turnaround 1,0 on writes
// - Read turnaround released; device drives second low
// - Sixteen data bits, MSB first
// - Read bits change after rising edge
// - Release data line when frame ends
// - Address bit 15 picks IEEE or chip space
// - Controller writes 0x2004 thrice for MAC side
// - Controller writes 0001,0001,1002 for line side
// - Reset leaves base pointers on line side
// - Device address zero only with MAC side
// - Controller runs prepare, wait, reset, poll sequence
// - Reserved bits written default, ignored read; the reset poll compares all 16 read bits to CTRL1_DONE
`timescale 1ns/1ps
`default_nettype none
module mcp_dev
    import mcp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hw_reset_pin_n,
    input wire logic [4:0] prtad_strap,
    mcp_mdio_if.dev link,
    output logic mac_side,
    output logic soft_reset,
    output logic wr_valid,
    output logic [4:0] wr_devad,
    output logic wr_chip,
    output logic [14:0] wr_addr,
    output logic [15:0] wr_data
);
    // =================================================================
    // State of the link-clock domain
    // =================================================================
    typedef enum logic [2:0] {S_PRE, S_ST, S_HDR, S_TA, S_DATA, S_SKIP} mcp_lstate_t;

    typedef struct packed {
        mcp_lstate_t st;
        logic [5:0] pre;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic [4:0] prtad;
        logic taken;
        mcp_op_t op;
        logic [4:0] dev;
        logic oe;
        logic o;
        logic [31:0][15:0] adr;
        logic [15:0] bp_a;
        logic [15:0] bp_b;
        logic [15:0] bp_c;
        logic [15:0] prep;
        logic mac;
        logic [4:0] busy;
        logic srst_t;
        logic wr_t;
        logic [4:0] wdev;
        logic [15:0] wadr;
        logic [15:0] wdat;
    } mcp_link_t;

    // =================================================================
    // State of the system-clock domain
    // =================================================================
    typedef struct packed {
        logic [1:0] mac_sy;
        logic [2:0] srst_sy;
        logic [2:0] wr_sy;
        logic srst;
        logic wv;
        logic [4:0] wdev;
        logic wchip;
        logic [14:0] wadr;
        logic [15:0] wdat;
    } mcp_user_t;

    mcp_link_t s;
    mcp_link_t next_s;
    mcp_user_t u;
    mcp_user_t next_u;

    // =================================================================
    // Helpers
    // =================================================================
    function automatic logic is_core(input logic [4:0] dev);
        return dev == DEVAD_PMA || dev == DEVAD_PCS;
    endfunction

    function automatic logic mac_sel(input logic [15:0] a, input logic [15:0] b,
                                     input logic [15:0] c);
        return a == BP_MAC && b == BP_MAC && c == BP_MAC;
    endfunction

    // Read data for the stored address of one device; unknown reads zero
    function automatic logic [15:0] rd_map(input mcp_link_t st, input logic [4:0] dev);
        logic [15:0] a;
        a = st.adr[dev];
        rd_map = 16'h0000;
        if (dev == DEVAD_VEND) begin
            case (a)
                REG_BP_A: rd_map = st.bp_a;
                REG_BP_B: rd_map = st.bp_b;
                REG_BP_C: rd_map = st.bp_c;
                REG_SRST_PREP: rd_map = st.prep;
                default: rd_map = 16'h0000;
            endcase
        end else if (is_core(dev) && a == REG_CTRL1) begin
            // Self-clearing reset bit stays up while the core resets
            rd_map = CTRL1_DONE | {st.busy != 5'h00, 15'h0000};
        end
    endfunction

    // =================================================================
    // Frame engine, clocked by the link clock
    // =================================================================
    logic [11:0] hdr;
    logic [15:0] wd;
    logic [15:0] cur;
    logic [1:0] hw_rst_sy;
    logic [1:0][4:0] strap_sy;

    // Reset and strap pins come from outside the link domain; two flops each
    always_ff @(posedge link.mdc) begin
        hw_rst_sy <= {hw_rst_sy[0], hw_reset_pin_n};
        strap_sy <= {strap_sy[0], prtad_strap};
    end

    always_comb begin
        next_s = s;
        hdr = {s.sh[10:0], link.mdio};
        wd = {s.sh[14:0], link.mdio};
        cur = s.adr[s.dev];
        // Straps are steady by the first edge after release
        if (!s.taken) begin
            next_s.prtad = strap_sy[1];
            next_s.taken = 1'b1;
        end
        if (s.busy != 5'h00) begin
            next_s.busy = s.busy - 5'h01;
        end
        unique case (s.st)
            S_PRE: begin
                // Every bit sampled on the rising edge of the link clock
                if (link.mdio) begin
                    next_s.pre = (s.pre == PRE_LEN) ? s.pre : s.pre + 6'h01;
                end else if (s.pre == PRE_LEN && link.mdio == ST_C45[1]) begin
                    next_s.st = S_ST;
                end else begin
                    next_s.pre = 6'h00;
                end
            end
            S_ST: begin
                next_s.pre = 6'h00;
                next_s.cnt = 5'h00;
                if (link.mdio == ST_C45[0]) begin
                    next_s.st = S_HDR;
                end else begin
                    // Other frame formats are sat out with the driver off
                    next_s.st = S_SKIP;
                    next_s.cnt = SKIP_AFTER_ST;
                end
            end
            S_HDR: begin
                // Opcode, port and device address, MSB first
                next_s.sh = {s.sh[14:0], link.mdio};
                next_s.cnt = s.cnt + 5'h01;
                if (s.cnt == HDR_LAST) begin
                    next_s.op = mcp_op_t'(hdr[11:10]);
                    next_s.dev = hdr[4:0];
                    next_s.cnt = 5'h00;
                    // Foreign port, or device zero without MAC-side pointers
                    if (hdr[9:5] == s.prtad &&
                        !(hdr[4:0] == DEVAD_SGMII && !s.mac)) begin
                        next_s.st = S_TA;
                        next_s.sh = rd_map(s, hdr[4:0]);
                    end else begin
                        next_s.st = S_SKIP;
                        next_s.cnt = SKIP_AFTER_HDR;
                    end
                end
            end
            S_TA: begin
                next_s.cnt = s.cnt + 5'h01;
                if (s.cnt == 5'h00) begin
                    // Driver on a bit early so the second turnaround bit is low
                    next_s.oe = s.op[1];
                    next_s.o = 1'b0;
                end else begin
                    next_s.o = s.sh[15];
                    next_s.sh = {s.sh[14:0], link.mdio};
                    next_s.st = S_DATA;
                    next_s.cnt = 5'h00;
                end
            end
            S_DATA: begin
                // Same shifter serves both directions, MSB first
                next_s.sh = {s.sh[14:0], link.mdio};
                next_s.o = s.sh[15];
                next_s.cnt = s.cnt + 5'h01;
                if (s.cnt == DATA_LAST) begin
                    next_s.oe = 1'b0;
                    next_s.st = S_PRE;
                    next_s.pre = 6'h00;
                    unique case (s.op)
                        OP_ADDR: begin
                            // Bit 15 kept: it selects chip or IEEE space
                            next_s.adr[s.dev] = wd;
                        end
                        OP_RDINC: begin
                            next_s.adr[s.dev] = cur + 16'h0001;
                        end
                        OP_READ: begin
                            next_s.adr[s.dev] = cur;
                        end
                        OP_WRITE: begin
                            if (s.dev == DEVAD_VEND) begin
                                case (cur)
                                    REG_BP_A: next_s.bp_a = wd;
                                    REG_BP_B: next_s.bp_b = wd;
                                    REG_BP_C: next_s.bp_c = wd;
                                    REG_SRST_PREP: next_s.prep = wd;
                                    default: next_s.prep = s.prep;
                                endcase
                            end
                            // Soft reset only after the prepare write
                            if (is_core(s.dev) && cur == REG_CTRL1 && wd[CTRL1_RST_BIT] &&
                                s.prep == SRST_PREP_VAL) begin
                                next_s.busy = SRST_MDC_CYC;
                                next_s.srst_t = ~s.srst_t;
                                next_s.bp_a = BP_LINE_AB;
                                next_s.bp_b = BP_LINE_AB;
                                next_s.bp_c = BP_LINE_C;
                                next_s.prep = 16'h0000;
                            end
                            next_s.wr_t = ~s.wr_t;
                            next_s.wdev = s.dev;
                            next_s.wadr = cur;
                            next_s.wdat = wd;
                        end
                    endcase
                end
            end
            S_SKIP: begin
                next_s.oe = 1'b0;
                next_s.cnt = s.cnt - 5'h01;
                if (s.cnt == 5'h00) begin
                    next_s.st = S_PRE;
                    next_s.pre = 6'h00;
                end
            end
        endcase
        // Registered so the crossing sees a clean level
        next_s.mac = mac_sel(next_s.bp_a, next_s.bp_b, next_s.bp_c);
    end

    // Reset is sampled on the link clock, which must run during it
    always_ff @(posedge link.mdc) begin
        if (!hw_rst_sy[1]) begin
            s <= '0;
            s.bp_a <= BP_LINE_AB;
            s.bp_b <= BP_LINE_AB;
            s.bp_c <= BP_LINE_C;
        end else begin
            s <= next_s;
        end
    end

    assign link.dev_o = s.o;
    assign link.dev_oe = s.oe;

    // =================================================================
    // Crossing to the system clock
    // =================================================================
    // Toggle events; write words stay put for a whole frame after the toggle
    always_comb begin
        next_u = u;
        next_u.mac_sy = {u.mac_sy[0], s.mac};
        next_u.srst_sy = {u.srst_sy[1:0], s.srst_t};
        next_u.wr_sy = {u.wr_sy[1:0], s.wr_t};
        next_u.srst = u.srst_sy[2] ^ u.srst_sy[1];
        next_u.wv = u.wr_sy[2] ^ u.wr_sy[1];
        if (u.wr_sy[2] ^ u.wr_sy[1]) begin
            next_u.wdev = s.wdev;
            next_u.wchip = s.wadr[ADDR_SPACE_BIT];
            next_u.wadr = s.wadr[14:0];
            next_u.wdat = s.wdat;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            u <= '0;
        end else begin
            u <= next_u;
        end
    end

    assign mac_side = u.mac_sy[1];
    assign soft_reset = u.srst;
    assign wr_valid = u.wv;
    assign wr_devad = u.wdev;
    assign wr_chip = u.wchip;
    assign wr_addr = u.wadr;
    assign wr_data = u.wdat;
endmodule
`default_nettype wire

// file: core/mcp_pkg.sv
// =====================================================================
// Shared constants for the management serial port and its controller
// =====================================================================
package mcp_pkg;
    // =================================================================
    // Frame layout
    // =================================================================
    localparam logic [5:0] PRE_LEN = 6'h20;
    localparam logic [1:0] ST_C45 = 2'b00;
    localparam logic [1:0] TA_WRITE = 2'b10;
    localparam logic [6:0] FRAME_BITS = 7'h40;
    localparam logic [6:0] TA_POS = 7'h2e;
    localparam logic [6:0] DATA_POS = 7'h30;
    localparam logic [4:0] HDR_LAST = 5'h0b;
    localparam logic [4:0] DATA_LAST = 5'h0f;
    localparam logic [4:0] SKIP_AFTER_ST = 5'h1d;
    localparam logic [4:0] SKIP_AFTER_HDR = 5'h11;
    localparam int ADDR_SPACE_BIT = 15;
    localparam int CTRL1_RST_BIT = 15;

    typedef enum logic [1:0] {
        OP_ADDR = 2'b00,
        OP_WRITE = 2'b01,
        OP_RDINC = 2'b10,
        OP_READ = 2'b11
    } mcp_op_t;

    // =================================================================
    // Device addresses and register offsets
    // =================================================================
    localparam logic [4:0] DEVAD_SGMII = 5'h00;
    localparam logic [4:0] DEVAD_PMA = 5'h01;
    localparam logic [4:0] DEVAD_PCS = 5'h03;
    localparam logic [4:0] DEVAD_VEND = 5'h1e;
    localparam logic [15:0] REG_CTRL1 = 16'h0000;
    localparam logic [15:0] REG_BP_A = 16'h4110;
    localparam logic [15:0] REG_BP_B = 16'h4111;
    localparam logic [15:0] REG_BP_C = 16'h4113;
    localparam logic [15:0] REG_SRST_PREP = 16'h4191;

    // =================================================================
    // Register values
    // =================================================================
    localparam logic [15:0] BP_MAC = 16'h2004;
    localparam logic [15:0] BP_LINE_AB = 16'h0001;
    localparam logic [15:0] BP_LINE_C = 16'h1002;
    localparam logic [15:0] SRST_PREP_VAL = 16'h0001;
    localparam logic [15:0] CTRL1_DONE = 16'h2040;

    // =================================================================
    // Timing
    // =================================================================
    localparam int MCLK_PERIOD_NS = 100;
    localparam int SRST_WAIT_NS = 200000;
    localparam int SRST_WAIT_CYC = (SRST_WAIT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam logic [4:0] SRST_MDC_CYC = 5'h10;

    typedef enum logic [1:0] {KIND_RAW, KIND_BP_MAC, KIND_BP_LINE, KIND_SRST} mcp_kind_t;
endpackage

// file: core/mcp_mdio_if.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Management link: clock from controller, shared data wire
// =====================================================================
interface mcp_mdio_if;
    logic mdc;
    logic host_o;
    logic host_oe;
    logic dev_o;
    logic dev_oe;
    logic mdio;

    // Wire level from the enables; idle pulls high
    assign mdio = host_oe ? host_o : (dev_oe ? dev_o : 1'b1);

    modport host (output mdc, output host_o, output host_oe, input mdio);
    modport dev (input mdc, input mdio, output dev_o, output dev_oe);
endinterface
`default_nettype wire

// file: core/mcp_host.sv
`timescale 1ns/1ps
`default_nettype none
module mcp_host
    import mcp_pkg::*;
#(
    parameter int MDC_HALF = 4
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire mcp_kind_t cmd_kind,
    input wire mcp_op_t cmd_op,
    input wire logic [4:0] cmd_prtad,
    input wire logic [4:0] cmd_devad,
    input wire logic [15:0] cmd_data,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    mcp_mdio_if.host link
);
    // =================================================================
    // State
    // =================================================================
    typedef enum logic [1:0] {H_IDLE, H_STEP, H_FRAME, H_WAIT} mcp_hstate_t;

    typedef struct packed {
        mcp_op_t op;
        logic [4:0] dev;
        logic [15:0] data;
        logic last;
        logic pause;
    } mcp_step_t;

    typedef struct packed {
        mcp_hstate_t st;
        mcp_kind_t kind;
        logic [2:0] idx;
        logic [4:0] prt;
        mcp_op_t op;
        logic [4:0] dev;
        logic [15:0] dat;
        mcp_op_t cur;
        logic mdc;
        logic [7:0] half;
        logic [6:0] cnt;
        logic [63:0] fr;
        logic oe;
        logic o;
        logic [1:0] sy;
        logic [15:0] rd;
        logic rv;
        logic [15:0] wt;
    } mcp_host_t;

    mcp_host_t s;
    mcp_host_t next_s;

    // =================================================================
    // Step table of the canned sequences
    // =================================================================
    function automatic mcp_step_t step_f(input mcp_host_t h);
        logic [15:0] reg_sel;
        logic [15:0] v;
        logic mac;
        mac = h.kind == KIND_BP_MAC;
        reg_sel = (h.idx[2:1] == 2'b00) ? REG_BP_A : (h.idx[2:1] == 2'b01) ? REG_BP_B : REG_BP_C;
        if (mac) begin
            v = BP_MAC;
        end else begin
            v = (h.idx[2:1] == 2'b10) ? BP_LINE_C : BP_LINE_AB;
        end
        step_f = '{h.op, h.dev, h.dat, 1'b1, 1'b0};
        if (h.kind == KIND_SRST) begin
            // Prepare, wait, set reset keeping defaults, then poll
            case (h.idx)
                3'h0: step_f = '{OP_ADDR, DEVAD_VEND, REG_SRST_PREP, 1'b0, 1'b0};
                3'h1: step_f = '{OP_WRITE, DEVAD_VEND, SRST_PREP_VAL, 1'b0, 1'b0};
                3'h2: step_f = '{OP_READ, DEVAD_PMA, 16'hffff, 1'b0, 1'b1};
                3'h3: step_f = '{OP_ADDR, DEVAD_PMA, REG_CTRL1, 1'b0, 1'b0};
                3'h4: step_f = '{OP_WRITE, DEVAD_PMA, CTRL1_DONE | 16'h8000, 1'b0, 1'b0};
                default: step_f = '{OP_READ, DEVAD_PMA, 16'hffff, 1'b1, 1'b0};
            endcase
        end else if (h.kind != KIND_RAW) begin
            step_f = '{h.idx[0] ? OP_WRITE : OP_ADDR, DEVAD_VEND, h.idx[0] ? v : reg_sel,
                       h.idx == 3'h5, 1'b0};
        end
    endfunction

    // =================================================================
    // Clock divider, sequencer and frame shifter
    // =================================================================
    mcp_step_t stp;
    logic tick;
    logic fall;

    always_comb begin
        next_s = s;
        next_s.rv = 1'b0;
        stp = step_f(s);
        tick = s.half == 8'(MDC_HALF - 1);
        // Data changes on the falling edge, mid-way between samples
        fall = tick && s.mdc;
        next_s.half = tick ? 8'h00 : s.half + 8'h01;
        if (tick) begin
            next_s.mdc = ~s.mdc;
        end
        next_s.sy = {s.sy[0], link.mdio};
        unique case (s.st)
            H_IDLE: begin
                if (cmd_valid) begin
                    next_s.kind = cmd_kind;
                    next_s.prt = cmd_prtad;
                    next_s.op = cmd_op;
                    next_s.dev = cmd_devad;
                    next_s.dat = cmd_data;
                    next_s.idx = 3'h0;
                    next_s.st = H_STEP;
                end
            end
            H_STEP: begin
                if (stp.pause) begin
                    next_s.wt = 16'h0000;
                    next_s.st = H_WAIT;
                end else begin
                    // Preamble, start, opcode, addresses, turnaround, data
                    next_s.fr = {32'hffffffff, ST_C45, stp.op, s.prt, stp.dev,
                                 stp.op[1] ? 2'b11 : TA_WRITE, stp.data};
                    next_s.cur = stp.op;
                    next_s.cnt = 7'h00;
                    next_s.st = H_FRAME;
                end
            end
            H_WAIT: begin
                next_s.wt = s.wt + 16'h0001;
                if (s.wt == 16'(SRST_WAIT_CYC - 1)) begin
                    next_s.idx = s.idx + 3'h1;
                    next_s.st = H_STEP;
                end
            end
            H_FRAME: begin
                if (fall) begin
                    if (s.cur[1] && s.cnt >= DATA_POS && s.cnt != FRAME_BITS) begin
                        next_s.rd = {s.rd[14:0], s.sy[1]};
                    end
                    if (s.cnt == FRAME_BITS) begin
                        next_s.oe = 1'b0;
                        if (s.kind == KIND_SRST && stp.last && s.rd != CTRL1_DONE) begin
                            next_s.st = H_STEP;
                        end else if (stp.last) begin
                            next_s.st = H_IDLE;
                            next_s.rv = 1'b1;
                        end else begin
                            next_s.idx = s.idx + 3'h1;
                            next_s.st = H_STEP;
                        end
                    end else begin
                        next_s.o = s.fr[63];
                        next_s.fr = {s.fr[62:0], 1'b1};
                        // Let go of the line for the read turnaround
                        next_s.oe = !(s.cur[1] && s.cnt >= TA_POS);
                        next_s.cnt = s.cnt + 7'h01;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cmd_ready = s.st == H_IDLE;
    assign rsp_valid = s.rv;
    assign rsp_data = s.rd;
    assign link.mdc = s.mdc;
    assign link.host_o = s.o;
    assign link.host_oe = s.oe;
endmodule
`default_nettype wire

// file: test/mcp_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================
// Link checks, sampled on mdc rise
module mcp_link_asserts (
    input wire logic mdc,
    input wire logic hw_reset_pin_n,
    input wire logic host_o,
    input wire logic host_oe,
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic mdio
);
    logic [5:0] ones;
    // Run of ones, saturates so long preambles still pass
    always_ff @(posedge mdc) begin
        if (!hw_reset_pin_n || !mdio) ones <= 6'h00;
        else if (ones != 6'h20) ones <= ones + 6'h01;
    end
    default clocking cb @(posedge mdc); endclocking
    default disable iff (!hw_reset_pin_n);
    sequence s_turn;
        !dev_o && !host_oe && !$past(host_oe);
    endsequence
    sequence s_data;
        ##16 dev_oe ##1 !dev_oe;
    endsequence
    a_no_fight: assert property (!(host_oe && dev_oe)) else $error("contention");
    a_turn_low: assert property ($rose(dev_oe) |-> s_turn) else $error("turn");
    a_data_len: assert property ($rose(dev_oe) |-> s_data) else $error("length");
    a_drive_off: assert property ($fell(dev_oe) |-> !dev_oe [*8]) else $error("off");
    a_pre_len: assert property ($rose(dev_oe) |-> $past(ones, 15) == 6'h20) else $error("pre");
    a_start_pat: assert property ($rose(dev_oe) |-> !$past(mdio, 15) && !$past(mdio, 14))
        else $error("start");
    a_read_op: assert property ($rose(dev_oe) |-> $past(mdio, 13)) else $error("op");
    a_pre_quiet: assert property (ones == 6'h20 |-> !dev_oe || host_o) else $error("q");
endmodule
`default_nettype wire

// file: test/mdio_clause45_mgmt_port_test.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================
// Both ends joined, driven via commands
module mdio_clause45_mgmt_port_test import mcp_pkg::*;;
    logic mclk = 0, rst_n = 0, hw_reset_pin_n = 0, cmd_valid = 0;
    logic cmd_ready, rsp_valid, mac_side, soft_reset, wr_valid, wr_chip;
    mcp_kind_t cmd_kind = KIND_RAW;
    mcp_op_t cmd_op = OP_ADDR;
    logic [4:0] cmd_prtad = 5'h05, cmd_devad = 5'h00, strap = 5'h05, wr_devad;
    logic [14:0] wr_addr;
    logic [15:0] cmd_data = 16'h0000, rsp_data, wr_data;
    int error_cnt = 0, check_count = 0, cyc = 0, wr_n = 0, rst_seen = 0;
    mcp_mdio_if mcp_mdio_if_i ();
    mcp_dev mcp_dev_i (.mclk(mclk), .rst_n(rst_n), .hw_reset_pin_n(hw_reset_pin_n),
        .prtad_strap(strap), .link(mcp_mdio_if_i.dev), .mac_side(mac_side),
        .soft_reset(soft_reset), .wr_valid(wr_valid), .wr_devad(wr_devad),
        .wr_chip(wr_chip), .wr_addr(wr_addr), .wr_data(wr_data));
    mcp_host #(.MDC_HALF(4)) mcp_host_i (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_op(cmd_op), .cmd_prtad(cmd_prtad),
        .cmd_devad(cmd_devad), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .link(mcp_mdio_if_i.host));
    mcp_link_asserts mcp_link_asserts_i (.mdc(mcp_mdio_if_i.mdc),
        .hw_reset_pin_n(hw_reset_pin_n), .host_o(mcp_mdio_if_i.host_o),
        .host_oe(mcp_mdio_if_i.host_oe), .dev_o(mcp_mdio_if_i.dev_o),
        .dev_oe(mcp_mdio_if_i.dev_oe), .mdio(mcp_mdio_if_i.mdio));
    initial forever #50 mclk = ~mclk;
    // Count device pulses; cap the run well above the longest sequence
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (wr_valid === 1'b1) wr_n <= wr_n + 1;
        if (soft_reset === 1'b1) rst_seen <= rst_seen + 1;
        if (cyc == 40000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
            error_cnt++;
        end
    endtask
    // One command; settle so the slow device pulses land first
    task automatic cmd(input mcp_kind_t k, input mcp_op_t o, input logic [4:0] d,
        input logic [15:0] v);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_op <= o;
        cmd_devad <= d;
        cmd_data <= v;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        while (rsp_valid !== 1'b1) @(negedge mclk);
        repeat (8) @(negedge mclk);
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // =====================================
    // Sequence of accesses
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (30) @(posedge mclk);
        hw_reset_pin_n <= 1'b1;
        repeat (20) @(posedge mclk);
        strap <= 5'h0a;
        cmd(KIND_RAW, OP_ADDR, DEVAD_VEND, REG_SRST_PREP);
        cmd(KIND_RAW, OP_WRITE, DEVAD_VEND, SRST_PREP_VAL);
        chk("wr_n", 16'h0001, 16'(wr_n));
        chk("wr_addr", REG_SRST_PREP, {wr_chip, wr_addr});
        chk("wr_data", SRST_PREP_VAL, wr_data);
        @(posedge mclk) cmd_prtad <= 5'h0a;
        cmd(KIND_RAW, OP_WRITE, DEVAD_VEND, 16'h0000);
        @(posedge mclk) cmd_prtad <= 5'h05;
        chk("foreign", 16'h0001, 16'(wr_n));
        cmd(KIND_RAW, OP_READ, DEVAD_VEND, 16'h0000);
        chk("prep", SRST_PREP_VAL, rsp_data);
        cmd(KIND_RAW, OP_ADDR, DEVAD_VEND, REG_BP_B);
        cmd(KIND_RAW, OP_RDINC, DEVAD_VEND, 16'h0000);
        chk("bp_b", BP_LINE_AB, rsp_data);
        cmd(KIND_RAW, OP_READ, DEVAD_VEND, 16'h0000);
        chk("inc", 16'h0000, rsp_data);
        cmd(KIND_RAW, OP_ADDR, DEVAD_VEND, REG_BP_C);
        cmd(KIND_RAW, OP_READ, DEVAD_VEND, 16'h0000);
        chk("bp_c", BP_LINE_C, rsp_data);
        cmd(KIND_RAW, OP_WRITE, DEVAD_SGMII, 16'h00aa);
        chk("dev0", 16'h0001, 16'(wr_n));
        cmd(KIND_BP_MAC, OP_ADDR, 5'h00, 16'h0000);
        chk("mac", 16'h0001, 16'(mac_side));
        cmd(KIND_RAW, OP_WRITE, DEVAD_SGMII, 16'h00aa);
        chk("dev0_mac", 16'h0000, 16'(wr_devad));
        cmd(KIND_BP_LINE, OP_ADDR, 5'h00, 16'h0000);
        chk("line", 16'h0000, 16'(mac_side));
        cmd(KIND_RAW, OP_ADDR, DEVAD_PMA, 16'h8005);
        cmd(KIND_RAW, OP_WRITE, DEVAD_PMA, 16'h1234);
        chk("chip", 16'h8005, {wr_chip, wr_addr});
        chk("data", 16'h1234, wr_data);
        cmd(KIND_SRST, OP_ADDR, 5'h00, 16'h0000);
        chk("done", CTRL1_DONE, rsp_data);
        chk("srst", 16'h0001, 16'(rst_seen));
        close_out();
    end
endmodule
`default_nettype wire
